// file: ttmq_pkg.sv
/*
 * package for the touch tracker and media queue register bank:
 * register offsets, field positions, reset values and the bus answer struct.
 * assumes a 32-bit apb slave with byte addresses as printed.
 */
package ttmq_pkg;
    // ========================================
    // register byte addresses
    localparam logic [15:0] TTMQ_OFF_POINT1 = 16'h7000;
    localparam logic [15:0] TTMQ_OFF_POINT2 = 16'h7004;
    localparam logic [15:0] TTMQ_OFF_POINT3 = 16'h7008;
    localparam logic [15:0] TTMQ_OFF_POINT4 = 16'h700c;
    localparam logic [15:0] TTMQ_OFF_POINT5 = 16'h7010;
    localparam logic [15:0] TTMQ_OFF_RD_PTR = 16'h7014;
    localparam logic [15:0] TTMQ_OFF_WR_PTR = 16'h7018;

    // ========================================
    // tracker field layout
    localparam int TTMQ_TRACK_MSB = 31;
    localparam int TTMQ_TRACK_LSB = 16;
    localparam int TTMQ_RSVD_MSB  = 15;
    localparam int TTMQ_RSVD_LSB  = 8;
    localparam int TTMQ_TAG_MSB   = 7;
    localparam int TTMQ_TAG_LSB   = 0;
    localparam int TTMQ_POINTS    = 5;

    // ========================================
    // reset values
    localparam logic [31:0] TTMQ_TRACK_RST = 32'h0000_0000;
    localparam logic [31:0] TTMQ_PTR_RST   = 32'h0000_0000;

    // one touch point report from the coprocessor
    typedef struct packed {
        logic        valid;  // update strobe
        logic [15:0] value;  // tracking value
        logic [7:0]  tag;    // touched object tag
    } ttmq_track_t;

    // registered bus answer
    typedef struct packed {
        logic [31:0] rdata;
        logic        slverr;
    } ttmq_answer_t;
endpackage : ttmq_pkg

// file: ttmq_regs.sv
/*
 * touch tracker and media queue register bank, apb slave.
 * assumes the coprocessor, touch engine and media consumer share the apb clock.
 */
`timescale 1ns/1ps
`default_nettype none

// ========================================
// register bank
// Summary of operation
// - tracker upper half holds tracking value
// - tracker low byte holds touched object tag
// - tracker bits fifteen to eight read zero
// - points two to five only in extended mode
// - read pointer read-only, resets to zero
// - write pointer write-only from software, resets zero
// - point one tracker below, same layout
module ttmq_regs (
    input  wire logic                 clock,        // 100 MHz
    input  wire logic                 reset,        // async, active high
    input  wire logic                 clk_en,       // freezes state when low
    input  wire logic                 psel,         // apb select
    input  wire logic                 penable,      // apb access phase
    input  wire logic                 pwrite,       // apb direction
    input  wire logic [15:0]          paddr,        // apb byte address
    input  wire logic [31:0]          pwdata,       // apb write data
    output logic                      pready,       // apb ready
    output logic [31:0]               prdata,       // apb read data
    output logic                      pslverr,      // apb error
    input  wire logic                 ext_mode,     // touch engine in extended mode
    input  wire ttmq_pkg::ttmq_track_t track_in [5], // per-point coprocessor reports
    input  wire logic                 media_adv,    // consumer took one word
    input  wire logic [31:0]          media_step,   // bytes consumed per advance
    output logic [31:0]               wr_ptr_out    // write pointer to the consumer
);
    // ========================================
    // state
    logic [31:0] track_reg [5];
    logic [31:0] track_next [5];
    logic [31:0] rd_ptr_reg;
    logic [31:0] rd_ptr_next;
    logic [31:0] wr_ptr_reg;
    logic [31:0] wr_ptr_next;
    ttmq_pkg::ttmq_answer_t ans_reg;
    ttmq_pkg::ttmq_answer_t ans_next;
    logic        rdy_reg;
    logic        rdy_next;

    // compose a tracker word with the reserved byte forced low
    function automatic logic [31:0] pack_track(input logic [15:0] v, input logic [7:0] t);
        pack_track = {v, 8'h00, t};
    endfunction : pack_track

    wire logic setup = psel && !penable;

    // next-state: tracker capture, pointers, zero-wait-state bus answer
    always_comb begin
        for (int i = 0; i < ttmq_pkg::TTMQ_POINTS; i++) begin
            track_next[i] = track_reg[i];
            if (track_in[i].valid && (i == 0 || ext_mode)) begin
                track_next[i] = pack_track(track_in[i].value, track_in[i].tag);
            end
        end
        // leaving extended mode clears stale multi-point content
        if (!ext_mode) begin
            for (int i = 1; i < ttmq_pkg::TTMQ_POINTS; i++) begin
                track_next[i] = ttmq_pkg::TTMQ_TRACK_RST;
            end
        end
        // an advance is blocked only while the read pointer equals the write pointer; a step that jumps past it is not stopped
        rd_ptr_next = rd_ptr_reg;
        if (media_adv && rd_ptr_reg != wr_ptr_reg) begin
            rd_ptr_next = rd_ptr_reg + media_step;
        end
        wr_ptr_next = wr_ptr_reg;
        rdy_next    = setup;
        ans_next    = '{rdata: 32'h0000_0000, slverr: 1'b0};
        if (setup) begin
            unique case (paddr)
                ttmq_pkg::TTMQ_OFF_POINT1: ans_next.rdata = pwrite ? 32'h0 : track_reg[0];
                ttmq_pkg::TTMQ_OFF_POINT2: ans_next.rdata = pwrite ? 32'h0 : track_reg[1];
                ttmq_pkg::TTMQ_OFF_POINT3: ans_next.rdata = pwrite ? 32'h0 : track_reg[2];
                ttmq_pkg::TTMQ_OFF_POINT4: ans_next.rdata = pwrite ? 32'h0 : track_reg[3];
                ttmq_pkg::TTMQ_OFF_POINT5: ans_next.rdata = pwrite ? 32'h0 : track_reg[4];
                ttmq_pkg::TTMQ_OFF_RD_PTR: ans_next.rdata = pwrite ? 32'h0 : rd_ptr_reg;
                ttmq_pkg::TTMQ_OFF_WR_PTR: begin
                    if (pwrite) begin
                        wr_ptr_next = pwdata;
                    end
                end
                default: ans_next.slverr = 1'b1; // unmapped address
            endcase
            // writes to read-only registers are ignored, not flagged
        end
    end

    // registers only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < ttmq_pkg::TTMQ_POINTS; i++) begin
                track_reg[i] <= ttmq_pkg::TTMQ_TRACK_RST;
            end
            rd_ptr_reg <= ttmq_pkg::TTMQ_PTR_RST;
            wr_ptr_reg <= ttmq_pkg::TTMQ_PTR_RST;
            ans_reg    <= '{rdata: 32'h0000_0000, slverr: 1'b0};
            rdy_reg    <= 1'b0;
        end else if (clk_en) begin
            track_reg  <= track_next;
            rd_ptr_reg <= rd_ptr_next;
            wr_ptr_reg <= wr_ptr_next;
            ans_reg    <= ans_next;
            rdy_reg    <= rdy_next;
        end
    end

    // outputs: the write pointer never reads back over the bus
    assign pready     = rdy_reg && psel && penable;
    assign prdata     = ans_reg.rdata;
    assign pslverr    = ans_reg.slverr && pready;
    assign wr_ptr_out = wr_ptr_reg;

    // ========================================
    // checks
    property p_rsvd_zero;
        @(posedge clock) disable iff (reset)
        track_reg[1][15:8] == 8'h00 && track_reg[0][15:8] == 8'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved tracker byte nonzero");

    property p_value_cap;
        @(posedge clock) disable iff (reset)
        (clk_en && ext_mode && track_in[1].valid) |=> track_reg[1][31:16] == $past(track_in[1].value);
    endproperty
    a_value_cap: assert property (p_value_cap) else $error("tracking value not captured");

    property p_tag_cap;
        @(posedge clock) disable iff (reset)
        (clk_en && ext_mode && track_in[4].valid) |=> track_reg[4][7:0] == $past(track_in[4].tag);
    endproperty
    a_tag_cap: assert property (p_tag_cap) else $error("tag not captured");

    property p_ext_only;
        @(posedge clock) disable iff (reset)
        (clk_en && !ext_mode) |=> track_reg[2] == 32'h0;
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("multi-point content outside extended mode");

    property p_point1;
        @(posedge clock) disable iff (reset)
        (clk_en && !ext_mode && track_in[0].valid) |=> track_reg[0][7:0] == $past(track_in[0].tag);
    endproperty
    a_point1: assert property (p_point1) else $error("first point not captured");

    property p_rd_hold;
        @(posedge clock) disable iff (reset)
        (clk_en && rd_ptr_reg == wr_ptr_reg && wr_ptr_next == wr_ptr_reg) |=> $stable(rd_ptr_reg);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read pointer passed write pointer");

    property p_rd_adv;
        @(posedge clock) disable iff (reset)
        (clk_en && media_adv && rd_ptr_reg != wr_ptr_reg) |=> rd_ptr_reg == $past(rd_ptr_reg) + $past(media_step);
    endproperty
    a_rd_adv: assert property (p_rd_adv) else $error("read pointer not advanced");

    sequence s_wr_access;
        psel && penable && pwrite && pready && paddr == ttmq_pkg::TTMQ_OFF_WR_PTR && clk_en;
    endsequence
    property p_wr_ptr;
        @(posedge clock) disable iff (reset)
        s_wr_access |-> ##1 wr_ptr_out == $past(pwdata, 2);
    endproperty
    a_wr_ptr: assert property (p_wr_ptr) else $error("write pointer not stored");

    property p_wo_read;
        @(posedge clock) disable iff (reset)
        (psel && penable && !pwrite && pready && paddr == ttmq_pkg::TTMQ_OFF_WR_PTR) |-> prdata == 32'h0;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only register read back");
endmodule : ttmq_regs

`default_nettype wire

// file: ttmq_regs_test.sv
/*
 * self-checking bench for the tracker and media queue register bank.
 * assumes ttmq_regs with its apb slave, one 100 MHz clock, no partner model.
 */
`timescale 1ns/1ps
`default_nettype none

// ========================================
// bench top
module ttmq_regs_test;
    logic                  clock = 1'b0;
    logic                  reset = 1'b1;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [15:0]           paddr = 16'h0;
    logic [31:0]           pwdata = 32'h0;
    logic                  ext_mode = 1'b0;
    logic                  media_adv = 1'b0;
    logic                  clk_en = 1'b1;
    logic [31:0]           media_step = 32'h0;
    ttmq_pkg::ttmq_track_t track_in [5];
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic [31:0]           wr_ptr_out;
    logic [15:0]           vals [5];
    logic [7:0]            tags [5];
    logic [31:0]           r;
    logic [31:0]           w;
    logic                  e;
    int                    errors = 0;
    int                    total_checks = 0;
    int                    cycles = 0;
    integer                seed = 32'hb9eb;
    logic [15:0] addrs [7] = '{ttmq_pkg::TTMQ_OFF_POINT1, ttmq_pkg::TTMQ_OFF_POINT2, ttmq_pkg::TTMQ_OFF_POINT3,
        ttmq_pkg::TTMQ_OFF_POINT4, ttmq_pkg::TTMQ_OFF_POINT5, ttmq_pkg::TTMQ_OFF_RD_PTR, ttmq_pkg::TTMQ_OFF_WR_PTR};

    always #5 clock = ~clock;

    // clk_en is driven so the freeze path is exercised too
    ttmq_regs dut (.clock(clock), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_mode(ext_mode),
        .track_in(track_in), .media_adv(media_adv), .media_step(media_step), .wr_ptr_out(wr_ptr_out));

    // ========================================
    // checking and bus tasks
    task results;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // pready is read in the active region of the rising edge, so it is the value the slave presents at that edge
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, r, e);
        check(name, exp, r);
        check("pslverr", 32'h0, {31'h0, e});
    endtask : rd_chk

    // points two to five read zero outside extended mode
    function automatic logic [31:0] exp_track(input int i, input logic ext);
        return (i == 0 || ext) ? {vals[i], 8'h00, tags[i]} : 32'h0;
    endfunction : exp_track

    // hang guard, far above the hundred or so cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results;
        end
    end

    // ========================================
    // main sequence
    initial begin
        for (int i = 0; i < 5; i++) track_in[i] = '0;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++) rd_chk("reset value", addrs[i], 32'h0);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            ext_mode <= m[0];
            @(posedge clock);
            for (int i = 0; i < 5; i++) begin
                vals[i] = 16'($random(seed));
                tags[i] = 8'($random(seed));
                track_in[i] <= '{1'b1, vals[i], tags[i]};
            end
            @(posedge clock);
            for (int i = 0; i < 5; i++) track_in[i].valid <= 1'b0;
            for (int i = 0; i < 5; i++) rd_chk("tracker", addrs[i], exp_track(i, m[0]));
        end
        $display("test trackers done");
        w = $random(seed);
        apb(1'b1, ttmq_pkg::TTMQ_OFF_WR_PTR, w, r, e);
        check("wr_ptr_out", w, wr_ptr_out);
        rd_chk("write-only read", ttmq_pkg::TTMQ_OFF_WR_PTR, 32'h0);
        apb(1'b1, ttmq_pkg::TTMQ_OFF_POINT2, ~w, r, e);
        rd_chk("read-only write", ttmq_pkg::TTMQ_OFF_POINT2, exp_track(1, 1'b1));
        apb(1'b0, 16'h701c, 32'h0, r, e);
        check("unmapped pslverr", 32'h1, {31'h0, e});
        $display("test access done");
        // six advances of four against a limit of 0x10: four land, two are held off
        apb(1'b1, ttmq_pkg::TTMQ_OFF_WR_PTR, 32'h10, r, e);
        media_step <= 32'h4;
        repeat (6) begin
            @(posedge clock);
            media_adv <= 1'b1;
            @(posedge clock);
            media_adv <= 1'b0;
        end
        rd_chk("read pointer", ttmq_pkg::TTMQ_OFF_RD_PTR, 32'h10);
        $display("test media queue done");
        // a strobe offered while the clock enable is low must not land
        clk_en <= 1'b0;
        track_in[0] <= '{1'b1, ~vals[0], ~tags[0]};
        @(posedge clock);
        track_in[0].valid <= 1'b0;
        clk_en <= 1'b1;
        rd_chk("frozen tracker", ttmq_pkg::TTMQ_OFF_POINT1, exp_track(0, 1'b1));
        $display("test freeze done");
        results;
    end
endmodule : ttmq_regs_test

`default_nettype wire
